// File: shared/lsag_pkg.sv
package lsag_pkg;
  localparam int unsigned DATA_W     = 32;  // datapath width
  localparam int unsigned IMM_W      = 12;  // immediate offset magnitude width
  localparam int unsigned SHAMT_W    = 5;   // constant shift amount width
  localparam int unsigned CHECK_W    = 6;   // top address bits that must be zero
  localparam logic [31:0] PC_AHEAD   = 32'h0000_0008;  // prefetch lead of the pc
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;  // value after reset

  // shift type encoding of the offset shifter
  typedef enum logic [1:0] {
    LSAG_LSL = 2'h0,
    LSAG_LSR = 2'h1,
    LSAG_ASR = 2'h2,
    LSAG_ROR = 2'h3
  } lsag_shift_t;

  // one decoded transfer request
  typedef struct packed {
    logic [31:0]  base_register;    // base value as read from the bank
    logic         base_is_pc;       // base is the program counter
    logic [31:0]  offset_register;  // offset register value
    logic         reg_offset;       // 1: register offset, 0: immediate
    logic         has_offset;       // 0: no offset form
    logic [11:0]  imm;              // immediate magnitude
    lsag_shift_t  shift_type;       // shifter type
    logic [4:0]   shift_amount;     // constant shift count
    logic         carry_in;         // carry flag for rotate_extended
    logic         pre_index;        // 1: pre-indexed, 0: post-indexed
    logic         up;               // 1: add offset, 0: subtract
    logic         write_back;       // write-back bit
    logic         byte_xfer;        // byte transfer
    logic         user_mode;        // processor in user mode
  } lsag_req_t;

  // computed transfer answer
  typedef struct packed {
    logic [31:0] xfer_addr;     // address put on the bus
    logic [31:0] new_base;      // value to write back to the base
    logic        base_we;       // write base back
    logic        translate_n;   // active-low translate output
    logic        addr_exc;      // address exception, transfer suppressed
    logic        byte_xfer;     // byte transfer
  } lsag_resp_t;
endpackage

// File: verilog/lsag_shifter.sv
`timescale 1ns/1ps
// offset barrel shifter with constant amount
module lsag_shifter #(
  parameter int unsigned W = 32  // data width
) (
  input  wire logic [W-1:0]         val_i,    // offset register value
  input  wire lsag_pkg::lsag_shift_t type_i,  // shift type
  input  wire logic [4:0]           amt_i,    // constant shift amount
  input  wire logic                 carry_i,  // carry for rotate_extended
  output logic      [W-1:0]         res_o     // shifted offset
);
  import lsag_pkg::*;

  // elaboration check: the rotate paths assume a 32-bit word
  if (W != 32) begin : gen_width_check
    $error("lsag_shifter supports only 32-bit data");
  end

  // combinational shifter; a zero amount on lsr/asr keeps plain encoding, on ror it selects rotate_extended
  always_comb begin
    res_o = val_i;
    unique case (type_i)
      LSAG_LSL: res_o = val_i << amt_i;
      LSAG_LSR: res_o = val_i >> amt_i;
      LSAG_ASR: res_o = W'($signed(val_i) >>> amt_i);
      LSAG_ROR: begin
        if (amt_i == 5'h00) begin
          res_o = {carry_i, val_i[W-1:1]};  // rotate_extended
        end else begin
          res_o = (val_i >> amt_i) | (val_i << (6'h20 - {1'b0, amt_i}));
        end
      end
    endcase
  end
endmodule

// File: verilog/lsag_core.sv
`timescale 1ns/1ps
module lsag_core #(
  parameter int unsigned DW = lsag_pkg::DATA_W  // datapath width
) (
  input  wire logic                   clk_i,         // processor clock
  input  wire logic                   arst_n_i,      // async reset, active low
  input  wire logic                   req_valid_i,   // request strobe
  input  wire lsag_pkg::lsag_req_t    req_i,         // decoded transfer fields
  input  wire logic [31:0]            rd_data_i,     // data bus for loads
  output logic                        resp_valid_o,  // answer valid, one cycle
  output lsag_pkg::lsag_resp_t        resp_o,        // registered answer
  output logic [31:0]                 load_data_o    // aligned load result
);
  import lsag_pkg::*;

  // one request in, one answer out: no queue and no refusal, so
  // back-to-back requests are answered on consecutive edges
  // the read bus is sampled only in the answer cycle; a transfer that
  // fails the range check leaves the load result untouched
  // the base write-back value is always computed, the strobe decides
  // whether the register bank takes it

  // elaboration check: the arithmetic below is written for a 32-bit word
  if (DW != DATA_W) begin : gen_width_check
    $error("lsag_core supports only 32-bit data");
  end

  logic [31:0] base_eff;     // base after pc adjust
  logic [31:0] shifted;      // shifter output
  logic [31:0] offset_val;   // selected offset magnitude
  logic [31:0] modified;     // base plus or minus offset
  logic [31:0] nxt_addr;     // transfer address
  logic        nxt_exc;      // address exception
  logic        nxt_we;       // write back strobe
  logic        nxt_tran_n;   // translate output
  logic        resp_valid_ff;  // registered valid
  logic [31:0] addr_ff;        // registered transfer address
  logic [31:0] base_ff;        // registered modified base
  logic        we_ff;          // registered write-back strobe
  logic        tran_n_ff;      // registered translate output, active low
  logic        exc_ff;         // registered address exception
  logic        byte_ff;        // registered byte transfer flag
  logic [31:0] load_ff;        // registered load data
  logic [1:0]  lane;           // byte lane of the transfer
  logic [7:0]  sel_byte;       // byte selected from the bus
  logic [31:0] nxt_load;       // next load result
  // load path candidates, one per byte lane
  logic [7:0]  lane_byte [4];  // each byte lane of the read bus
  logic [31:0] lane_word [4];  // read word rotated for each lane

  // offset shifter, amount only from the instruction constant
  lsag_shifter #(
    .W (DW)
  ) u_shift (
    .val_i   (req_i.offset_register),
    .type_i  (req_i.shift_type),
    .amt_i   (req_i.shift_amount),
    .carry_i (req_i.carry_in),
    .res_o   (shifted)
  );

  // base adjust: the pc reads eight bytes ahead because of prefetch
  always_comb begin
    if (req_i.base_is_pc) begin
      base_eff = req_i.base_register + PC_AHEAD;
    end else begin
      base_eff = req_i.base_register;             // plain register base
    end
  end

  // offset select: none, immediate magnitude or shifted register
  always_comb begin
    if (!req_i.has_offset) begin
      offset_val = RST_WORD;
    end else if (req_i.reg_offset) begin
      // a zero-amount lsl leaves the register untouched; other zero
      // amounts are decided inside the shifter
      if (req_i.shift_type == LSAG_LSL && req_i.shift_amount == 5'h00) begin
        offset_val = req_i.offset_register;
      end else begin
        offset_val = shifted;
      end
    end else begin
      offset_val = {20'h00000, req_i.imm};
    end
  end

  // direction: the up bit picks add or subtract
  always_comb begin
    if (req_i.up) begin
      modified = base_eff + offset_val;
    end else begin
      modified = base_eff - offset_val;
    end
  end

  // transfer address by indexing mode, and the range check on it
  always_comb begin
    if (req_i.pre_index) begin
      nxt_addr = modified;
    end else begin
      nxt_addr = base_eff;
    end
    // only the address actually used is checked, never the new base
    nxt_exc = |nxt_addr[31:32-CHECK_W];
  end

  // write-back strobe and translate output for the answer
  always_comb begin
    if (req_i.pre_index) begin
      nxt_we     = req_i.write_back;
      nxt_tran_n = 1'b1;                          // pre-indexed never forces
    end else begin
      nxt_we     = 1'b1;
      // write-back bit forces translate low outside user mode
      nxt_tran_n = !(req_i.write_back && !req_i.user_mode);
    end
  end

  // answer valid: a one-cycle pulse one edge after the request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resp_valid_ff <= 1'b0;
    end else begin
      resp_valid_ff <= req_valid_i;  // every request is answered
    end
  end

  // address and base fields: held until the next request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_ff <= RST_WORD;
      base_ff <= RST_WORD;
      exc_ff  <= 1'b0;
      byte_ff <= 1'b0;
    end else if (req_valid_i) begin
      // capture the answer for the request taken at this edge
      addr_ff <= nxt_addr;
      base_ff <= modified;
      exc_ff  <= nxt_exc;
      byte_ff <= req_i.byte_xfer;
    end
  end

  // write-back strobe: high only in the answer cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      we_ff <= 1'b0;
    end else if (req_valid_i) begin
      we_ff <= nxt_we;
    end else begin
      we_ff <= 1'b0;                  // no strobe without an answer
    end
  end

  // translate output: low only in the answer cycle of a forced transfer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tran_n_ff <= 1'b1;              // idle level is high
    end else if (req_valid_i) begin
      tran_n_ff <= nxt_tran_n;
    end else begin
      tran_n_ff <= 1'b1;              // released after one cycle
    end
  end

  // candidate results for each byte lane of the read bus
  // lane 0 is the low byte, matching the little-endian byte order
  for (genvar g = 0; g < 4; g++) begin : gen_lane
    // byte lane g sits in bits 8*g+7 down to 8*g
    assign lane_byte[g] = rd_data_i[8*g +: 8];
    // word rotated right so that lane g lands in bits 7:0
    if (g == 0) begin : gen_aligned
      assign lane_word[g] = rd_data_i;
    end else begin : gen_rotated
      assign lane_word[g] = {rd_data_i[8*g-1:0], rd_data_i[31:8*g]};
    end
  end

  // load alignment: byte zero-fill, word rotated to addressed byte
  always_comb begin
    lane     = addr_ff[1:0];          // lane picked by the held address
    sel_byte = lane_byte[lane];
    if (byte_ff) begin
      nxt_load = {24'h000000, sel_byte};
    end else begin
      nxt_load = lane_word[lane];     // unaligned word rotated into place
    end
  end

  // load result register, captured one cycle after the answer
  // a suppressed transfer must not disturb the destination
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_ff <= RST_WORD;
    end else if (resp_valid_ff && !exc_ff) begin
      load_ff <= nxt_load;
    end
  end

  // outputs come straight from the flops above
  assign resp_valid_o = resp_valid_ff;
  assign resp_o       = '{xfer_addr: addr_ff, new_base: base_ff, base_we: we_ff,
                          translate_n: tran_n_ff, addr_exc: exc_ff, byte_xfer: byte_ff};
  assign load_data_o  = load_ff;
endmodule

// File: sim/lsag_mem_model.sv
`timescale 1ns/1ps
// memory answering a read with an address-derived pattern
module lsag_mem_model (
  input  wire logic        sel_i,   // transfer cycle
  input  wire logic [31:0] addr_i,  // transfer address
  output logic      [31:0] data_o   // read data bus
);
  // outside the transfer cycle the bus shows garbage, not held data
  always_comb begin
    data_o = sel_i ? (addr_i ^ 32'h5A3C_96E1) : ~(addr_i ^ 32'h5A3C_96E1);
  end
endmodule

// File: sim/lsag_core_chk.sv
`timescale 1ns/1ps
module lsag_core_chk (
  input wire logic                 clk_i,
  input wire logic                 arst_n_i,
  input wire logic                 req_valid_i,
  input wire lsag_pkg::lsag_req_t  req_i,
  input wire logic [31:0]          rd_data_i,
  input wire logic                 resp_valid_o,
  input wire lsag_pkg::lsag_resp_t resp_o,
  input wire logic [31:0]          load_data_o
);
  import lsag_pkg::*;
  logic        r_ff;  // request taken last edge
  lsag_req_t   q_ff;  // its fields
  logic [31:0] off;   // unshifted offset
  logic [31:0] b;     // base as seen
  logic [31:0] nb;    // modified base
  logic        plain; // offset needs no shifting
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) r_ff <= 1'h0;
    else r_ff <= req_valid_i;
  end
  always_ff @(posedge clk_i) begin
    q_ff <= req_i;
  end
  assign off = q_ff.reg_offset ? q_ff.offset_register : {20'h0, q_ff.imm};
  assign b = q_ff.base_register + (q_ff.base_is_pc ? PC_AHEAD : 32'h0);
  assign nb = !q_ff.has_offset ? b : q_ff.up ? b + off : b - off;
  assign plain = !q_ff.reg_offset || (q_ff.shift_amount == 5'h0 && q_ff.shift_type == LSAG_LSL);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_ANSWER: assert property (resp_valid_o == r_ff)
    else $error("answer pulse");
  AST_PRE: assert property (r_ff && plain && q_ff.pre_index |-> resp_o.xfer_addr == nb)
    else $error("pre address");
  AST_POST: assert property (r_ff && !q_ff.pre_index |-> resp_o.xfer_addr == b)
    else $error("post address");
  AST_NEWBASE: assert property (r_ff && plain |-> resp_o.new_base == nb)
    else $error("new base");
  AST_WB_PRE: assert property (r_ff && q_ff.pre_index |-> resp_o.base_we == q_ff.write_back)
    else $error("pre write back");
  AST_WB_POST: assert property (r_ff && !q_ff.pre_index |-> resp_o.base_we)
    else $error("post write back");
  AST_TRAN: assert property (r_ff |-> resp_o.translate_n == (q_ff.pre_index || !q_ff.write_back || q_ff.user_mode))
    else $error("translate");
  AST_TRAP: assert property (resp_valid_o |-> resp_o.addr_exc == (|resp_o.xfer_addr[31:26]))
    else $error("trap");
  AST_BYTE: assert property (resp_valid_o && resp_o.byte_xfer && !resp_o.addr_exc |=> load_data_o[31:8] == 24'h0)
    else $error("byte fill");
  AST_IDLE: assert property (!resp_valid_o |-> resp_o.translate_n && !resp_o.base_we)
    else $error("strobe outside answer");
  AST_HOLD: assert property (resp_valid_o && resp_o.addr_exc |=> $stable(load_data_o))
    else $error("suppressed load changed");
  cover property (resp_valid_o && resp_o.byte_xfer && !resp_o.addr_exc);
  cover property (r_ff && !q_ff.pre_index && q_ff.write_back);
  cover property (resp_valid_o && resp_o.addr_exc);
  cover property (r_ff && q_ff.shift_type == LSAG_ROR && q_ff.shift_amount == 5'h0);
endmodule
bind lsag_core lsag_core_chk chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .rd_data_i(rd_data_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o), .load_data_o(load_data_o));

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import lsag_pkg::*;
  logic        clk_i = 1'h0, arst_n_i = 1'h0, req_valid_i = 1'h0, resp_valid_o;
  lsag_req_t   req_i = '0;
  lsag_resp_t  resp_o;
  logic [31:0] rd_data_i, load_data_o;
  int          fail_count = 0, num_checks = 0;
  always #50 clk_i = ~clk_i;
  lsag_core dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .rd_data_i(rd_data_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o), .load_data_o(load_data_o));
  lsag_mem_model mem (.sel_i(resp_valid_o), .addr_i(resp_o.xfer_addr), .data_o(rd_data_i));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // flags f: pc, reg, has offset, carry, pre, up, write back, byte
  function automatic lsag_req_t rq(logic [31:0] b, o, logic [11:0] im, lsag_shift_t t, logic [4:0] a, logic [7:0] f);
    rq = {b, f[7], o, f[6], f[5], im, t, a, f[4], f[3], f[2], f[1], f[0], 1'h0};
  endfunction
  // one request pulse; the answer is up at the following falling edge
  task automatic go(lsag_req_t r);
    @(negedge clk_i);
    req_i = r;
    req_valid_i = 1'h1;
    @(negedge clk_i);
    req_valid_i = 1'h0;
  endtask
  task automatic ans(logic [31:0] ea, nb, logic [2:0] f);
    chk("addr", resp_o.xfer_addr, ea);
    chk("base", resp_o.new_base, nb);
    chk("flags", {resp_valid_o, resp_o.base_we, resp_o.translate_n, resp_o.addr_exc}, {1'h1, f});
  endtask
  task automatic t_pre_imm;
    go(rq(32'h0000_1000, 32'h0, 12'hFFF, LSAG_LSL, 5'h0, 8'h2C));
    ans(32'h0000_1FFF, 32'h0000_1FFF, 3'h2);
    go(rq(32'h0000_1000, 32'h0, 12'h004, LSAG_LSL, 5'h0, 8'h2A));
    ans(32'h0000_0FFC, 32'h0000_0FFC, 3'h6);
  endtask
  task automatic t_post;
    go(rq(32'h0000_2000, 32'h0000_0100, 12'h0, LSAG_LSR, 5'h4, 8'h66));
    ans(32'h0000_2000, 32'h0000_2010, 3'h4);
    @(negedge clk_i);
    chk("release", {resp_valid_o, resp_o.base_we, resp_o.translate_n}, 3'h1);
    go(rq(32'h03FF_FFFC, 32'h0, 12'h004, LSAG_LSL, 5'h0, 8'h24));
    ans(32'h03FF_FFFC, 32'h0400_0000, 3'h6);
  endtask
  task automatic t_shift;
    lsag_shift_t ty[6] = '{LSAG_LSL, LSAG_LSL, LSAG_LSR, LSAG_ASR, LSAG_ROR, LSAG_ROR};
    logic [4:0]  am[6] = '{5'h1, 5'h0, 5'h4, 5'h4, 5'h4, 5'h0};
    logic [31:0] ex[6] = '{32'h0000_01E2, 32'h8000_00F1, 32'h0800_000F, 32'hF800_000F, 32'h1800_000F, 32'hC000_0078};
    for (int i = 0; i < 6; i++) begin
      go(rq(32'h0, 32'h8000_00F1, 12'h0, ty[i], am[i], 8'h7C));
      chk("shifted", resp_o.new_base, ex[i]);
      chk("trap", resp_o.addr_exc, |ex[i][31:26]);
    end
  endtask
  task automatic t_pc_byte;
    go(rq(32'h0000_3000, 32'h0, 12'h0, LSAG_LSL, 5'h0, 8'h88));
    ans(32'h0000_3008, 32'h0000_3008, 3'h2);
    go(rq(32'h0000_1002, 32'h0, 12'h0, LSAG_LSL, 5'h0, 8'h09));
    ans(32'h0000_1002, 32'h0000_1002, 3'h2);
    @(negedge clk_i);
    chk("byte", load_data_o, 32'h0000_003C);
  endtask
  task automatic t_user_word;
    lsag_req_t r;
    r = rq(32'h0000_4000, 32'h0, 12'h010, LSAG_LSL, 5'h0, 8'h26);
    r.user_mode = 1'h1;
    go(r);
    ans(32'h0000_4000, 32'h0000_4010, 3'h6);
    go(rq(32'h0000_1001, 32'h0, 12'h0, LSAG_LSL, 5'h0, 8'h08));
    ans(32'h0000_1001, 32'h0000_1001, 3'h2);
    @(negedge clk_i);
    chk("word", load_data_o, 32'hE05A_3C86);
    go(rq(32'hFC00_0000, 32'h0, 12'h0, LSAG_LSL, 5'h0, 8'h09));
    ans(32'hFC00_0000, 32'hFC00_0000, 3'h3);
    @(negedge clk_i);
    chk("suppressed", load_data_o, 32'hE05A_3C86);
  endtask
  task automatic t_reset;
    @(negedge clk_i);
    arst_n_i = 1'h0;
    @(negedge clk_i);
    chk("reset flags", {resp_valid_o, resp_o.base_we, resp_o.translate_n, resp_o.addr_exc}, 4'h2);
    chk("reset load", load_data_o, 32'h0);
    chk("reset addr", resp_o.xfer_addr, 32'h0);
    arst_n_i = 1'h1;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'h1;
    t_pre_imm;
    t_post;
    t_shift;
    t_pc_byte;
    t_user_word;
    t_reset;
    t_pre_imm;
    test_done;
  end
  // watchdog well beyond the seventeen transfers
  initial begin
    #100000;
    fail_count++;
    test_done;
  end
endmodule
